// File: clb_switch_ctrl.sv
// critical current mode switching-cycle controller of a buck LED driver
// assumes comparator outputs as asynchronous levels and an external gate driver
`timescale 1ns/1ps
`default_nettype none

module clb_switch_ctrl
   import clb_pkg::*;
#(
   parameter logic [CNT_W-1:0] RESTART_CYC = RESTART_CYC_DEF,
   parameter logic [CNT_W-1:0] STANDBY_CYC = STANDBY_CYC_DEF
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic cs_trip_i,
   input wire logic bd_low_i,
   input wire logic pwm_on_i,
   input wire logic sel_in_band_i,
   input wire logic [1:0] sel_code_i,
   output logic gate_o,
   output logic [1:0] current_ref_o,
   output logic standby_o,
   output logic restart_wait_o
);

   // ==========================================================
   // input filter
   clb_cmp_if cmp ();

   clb_sync #(
      .W(CMP_W)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .raw_i({sel_code_i, sel_in_band_i, pwm_on_i, bd_low_i, cs_trip_i}),
      .cmp(cmp)
   );

   // ==========================================================
   // controller state
   clb_ctrl_type q;
   clb_ctrl_type d;
   logic run;

   always_comb begin
      d = q;
      // level select window code, held while between bands
      if (cmp.sel_in_band) begin // [R13]
         d.ref_code = cmp.sel_code; // [R08]
      end

      // enabled and dimming on
      run = (q.ref_code != REF_DISABLE) && cmp.pwm_on; // [R07] [R12]

      // standby timer on a continuously off PWM input
      if (cmp.pwm_on) begin
         d.stby_cnt = CNT_ZERO;
         d.standby = 1'b0; // [R11]
      end else if (!q.standby) begin
         d.stby_cnt = q.stby_cnt + CNT_ONE;
         if (q.stby_cnt == STANDBY_CYC - CNT_ONE) begin
            d.standby = 1'b1; // [R10]
         end
      end

      case (q.state)
         CLB_IDLE: begin
            if (run) begin
               d.state = CLB_ON; // [R12]
               d.gate = 1'b1;
               d.timer = CNT_ZERO;
            end
         end
         CLB_ON: begin
            if (cmp.cs_trip) begin
               d.state = CLB_OFF; // [R01]
               d.gate = 1'b0;
               d.timer = CNT_ZERO;
            end else if (q.timer == MAXON_CYC - CNT_ONE) begin
               d.state = CLB_WAIT; // [R05]
               d.gate = 1'b0;
               d.restart = 1'b1;
               d.timer = CNT_ZERO;
            end else begin
               d.timer = q.timer + CNT_ONE;
            end
         end
         CLB_OFF: begin
            if ((q.timer >= MASK_CYC) && cmp.bd_low) begin // [R03]
               d.state = CLB_ON; // [R02]
               d.gate = 1'b1;
               d.timer = CNT_ZERO;
            end else if (q.timer == TOUT_CYC - CNT_ONE) begin
               d.state = CLB_ON; // [R04]
               d.gate = 1'b1;
               d.timer = CNT_ZERO;
            end else begin
               d.timer = q.timer + CNT_ONE;
            end
         end
         CLB_WAIT: begin
            if (q.timer == RESTART_CYC - CNT_ONE) begin
               d.state = CLB_ON; // [R06]
               d.gate = 1'b1;
               d.restart = 1'b0;
               d.timer = CNT_ZERO;
            end else begin
               d.timer = q.timer + CNT_ONE;
            end
         end
         default: begin
            d.state = CLB_IDLE;
            d.gate = 1'b0;
            d.timer = CNT_ZERO;
         end
      endcase

      // disable or dimming off overrides any cycle in progress
      if (!run) begin
         d.state = CLB_IDLE; // [R07] [R12]
         d.gate = 1'b0;
         d.restart = 1'b0;
         d.timer = CNT_ZERO;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         q <= '{state: CLB_IDLE, timer: CNT_ZERO, stby_cnt: CNT_ZERO, gate: 1'b0,
                standby: 1'b0, restart: 1'b0, ref_code: REF_DISABLE};
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign gate_o = q.gate;
   assign current_ref_o = q.ref_code;
   assign standby_o = q.standby;
   assign restart_wait_o = q.restart;

   // ==========================================================
   // checks on the switching cycle
   a_cs_ends_on: assert property ( // [R01]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_ON) && cmp.cs_trip |=> !gate_o && !restart_wait_o)
      else $error("current-sense trip did not end the on-time");

   a_bd_starts_on: assert property ( // [R02]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_OFF) && (q.timer >= MASK_CYC) && cmp.bd_low && run
      |=> gate_o && (q.state == CLB_ON))
      else $error("bottom detection did not start the next cycle");

   a_mask_holds: assert property ( // [R03]
      @(posedge ref_clk_i) disable iff (rst_i)
      $fell(gate_o) && (q.state == CLB_OFF) |-> !gate_o [*8])
      else $error("gate rose inside the bottom mask time");

   a_mask_count: assert property ( // [R03]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_ON) && $past(q.state) == CLB_OFF && $past(gate_o) == 1'b0
      && $past(q.timer) < MASK_CYC |-> $past(q.timer) == TOUT_CYC - CNT_ONE)
      else $error("off-time ended before the mask time elapsed");

   a_bottom_timeout: assert property ( // [R04]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_OFF) && (q.timer == TOUT_CYC - CNT_ONE) && run |=> gate_o)
      else $error("bottom timeout did not force the gate high");

   a_off_bounded: assert property ( // [R04]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_OFF) |-> q.timer < TOUT_CYC)
      else $error("off-time ran past the bottom timeout");

   a_max_on_limit: assert property ( // [R05]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_ON) && !cmp.cs_trip && (q.timer == MAXON_CYC - CNT_ONE) && run
      |=> !gate_o && restart_wait_o)
      else $error("maximum on-time did not force the gate low");

   a_on_bounded: assert property ( // [R05]
      @(posedge ref_clk_i) disable iff (rst_i)
      gate_o |-> q.timer < MAXON_CYC)
      else $error("on-time exceeded its maximum");

   a_restart_hold: assert property ( // [R06]
      @(posedge ref_clk_i) disable iff (rst_i)
      restart_wait_o |-> !gate_o && (q.timer < RESTART_CYC))
      else $error("gate high during restart wait");

   a_restart_end: assert property ( // [R06]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_WAIT) && (q.timer == RESTART_CYC - CNT_ONE) && run
      |=> gate_o && !restart_wait_o)
      else $error("restart wait did not raise the gate");

   a_disable_low: assert property ( // [R07]
      @(posedge ref_clk_i) disable iff (rst_i)
      (current_ref_o == REF_DISABLE) |=> !gate_o)
      else $error("gate high while disabled");

   a_ref_follows: assert property ( // [R08]
      @(posedge ref_clk_i) disable iff (rst_i)
      cmp.sel_in_band |=> current_ref_o == $past(cmp.sel_code))
      else $error("current reference did not follow the level code");

   a_ref_holds: assert property ( // [R13]
      @(posedge ref_clk_i) disable iff (rst_i)
      !cmp.sel_in_band |=> $stable(current_ref_o))
      else $error("current reference changed between bands");

   a_standby_enter: assert property ( // [R10]
      @(posedge ref_clk_i) disable iff (rst_i)
      !cmp.pwm_on && !standby_o && (q.stby_cnt == STANDBY_CYC - CNT_ONE) |=> standby_o)
      else $error("standby not entered after the off delay");

   a_standby_early: assert property ( // [R10]
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(standby_o) |-> $past(q.stby_cnt) == STANDBY_CYC - CNT_ONE)
      else $error("standby entered early");

   a_standby_leave: assert property ( // [R11]
      @(posedge ref_clk_i) disable iff (rst_i)
      cmp.pwm_on |=> !standby_o)
      else $error("standby not left on PWM on");

   a_pwm_off_low: assert property ( // [R12]
      @(posedge ref_clk_i) disable iff (rst_i)
      !cmp.pwm_on |=> !gate_o)
      else $error("gate high while dimming off");

   a_pwm_resume: assert property ( // [R12]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_IDLE) && run |=> gate_o)
      else $error("switching did not resume");

   // ==========================================================
   // checks on the cycle bookkeeping
   a_gate_in_on: assert property ( // [R01]
      @(posedge ref_clk_i) disable iff (rst_i)
      gate_o == (q.state == CLB_ON))
      else $error("gate level does not match the on state");

   a_fall_cause: assert property ( // [R01]
      @(posedge ref_clk_i) disable iff (rst_i)
      $fell(gate_o) |-> $past(cmp.cs_trip) || !$past(run)
      || ($past(q.timer) == MAXON_CYC - CNT_ONE))
      else $error("gate fell without a trip, a limit or a stop");

   a_rise_cause: assert property ( // [R02]
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(gate_o) && ($past(q.state) == CLB_OFF)
      |-> $past(cmp.bd_low) || ($past(q.timer) == TOUT_CYC - CNT_ONE))
      else $error("off-time ended without a detection or a timeout");

   a_on_start: assert property ( // [R02]
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(gate_o) |-> (q.timer == CNT_ZERO) && !restart_wait_o)
      else $error("on-time did not start from a cleared timer");

   a_off_start: assert property ( // [R03]
      @(posedge ref_clk_i) disable iff (rst_i)
      $fell(gate_o) && (q.state == CLB_OFF) |-> q.timer == CNT_ZERO)
      else $error("mask time not counted from the turn-off");

   a_wait_cause: assert property ( // [R06]
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(restart_wait_o)
      |-> ($past(q.state) == CLB_ON) && ($past(q.timer) == MAXON_CYC - CNT_ONE))
      else $error("restart wait began without a maximum on-time");

   a_wait_state: assert property ( // [R06]
      @(posedge ref_clk_i) disable iff (rst_i)
      restart_wait_o |-> q.state == CLB_WAIT)
      else $error("restart flag outside the wait state");

   a_stop_cancel: assert property ( // [R07]
      @(posedge ref_clk_i) disable iff (rst_i)
      !run |=> !restart_wait_o && (q.state == CLB_IDLE))
      else $error("stopped block kept a cycle or a restart wait");

   a_stby_full: assert property ( // [R10]
      @(posedge ref_clk_i) disable iff (rst_i)
      standby_o |-> q.stby_cnt == STANDBY_CYC)
      else $error("standby counter not at its full count");

   a_stby_step: assert property ( // [R10]
      @(posedge ref_clk_i) disable iff (rst_i)
      !cmp.pwm_on && !standby_o
      |=> q.stby_cnt == $past(q.stby_cnt) + CNT_ONE)
      else $error("standby counter skipped while the PWM input was off");

   a_stby_clear: assert property ( // [R11]
      @(posedge ref_clk_i) disable iff (rst_i)
      cmp.pwm_on |=> q.stby_cnt == CNT_ZERO)
      else $error("standby counter not cleared by PWM on");

   a_stby_gate: assert property ( // [R12]
      @(posedge ref_clk_i) disable iff (rst_i)
      standby_o |-> !gate_o)
      else $error("gate high in standby");

   a_ref_change: assert property ( // [R13]
      @(posedge ref_clk_i) disable iff (rst_i)
      $changed(current_ref_o) |-> $past(cmp.sel_in_band))
      else $error("current reference changed outside a band");

   a_on_count: assert property ( // [R05]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_ON) && ($past(q.state) == CLB_ON)
      |-> q.timer == $past(q.timer) + CNT_ONE)
      else $error("on-time timer did not advance");

   a_off_count: assert property ( // [R04]
      @(posedge ref_clk_i) disable iff (rst_i)
      (q.state == CLB_OFF) && ($past(q.state) == CLB_OFF)
      |-> q.timer == $past(q.timer) + CNT_ONE)
      else $error("off-time timer did not advance");

endmodule // clb_switch_ctrl

`default_nettype wire

// File: clb_pkg.sv
// constants, types and timing counts of the buck switching-cycle controller
// assumes a single 125 MHz reference clock and a synchronous active-high reset
//
// Function
// R01: a current-sense trip while the gate is high drives the gate low and ends the on-time.
// R02: in the off-time a bottom detection (drain level at or below 100 mV) raises the gate again.
// R03: bottom detections are ignored for the 0.62 us mask time after each gate turn-off.
// R04: without a bottom detection 20 us after turn-off the gate is forced high.
// R05: an on-time reaching the 20 us maximum without a current-sense trip forces the gate low.
// R06: after a maximum on-time turn-off the gate is raised again after a 570 us restart wait.
// R07: a level select at or below 0.4 V disables the block and holds the gate low.
// R08: the current reference is 750, 1000 or 1100 mV according to the level select band.
// R09: the dimming source drives the PWM input above 2 V for on and below 1.1 V for off.
// R10: the PWM input held off for 36 ms or longer puts the block into standby.
// R11: the PWM input turning on leaves standby at once.
// R12: while the PWM input is off the gate stays low, and cycles resume when it turns on.
// R13: level select arrives as a two-bit window code and the last code is kept between bands.

package clb_pkg;

   // ==========================================================
   // timebase
   localparam real CLK_PERIOD_NS = 8.0;
   localparam int CNT_W = 24;

   localparam real BOTTOM_MASK_US = 0.62;
   localparam real BOTTOM_TIMEOUT_US = 20.0;
   localparam real MAX_ON_TIME_US = 20.0;
   localparam real RESTART_WAIT_US = 570.0;
   localparam real STANDBY_DELAY_MS = 36.0;

   // least time rounds up, longest time rounds down
   localparam logic [CNT_W-1:0] MASK_CYC =
      CNT_W'($rtoi($ceil(BOTTOM_MASK_US * 1000.0 / CLK_PERIOD_NS)));
   localparam logic [CNT_W-1:0] TOUT_CYC =
      CNT_W'($rtoi($floor(BOTTOM_TIMEOUT_US * 1000.0 / CLK_PERIOD_NS)));
   localparam logic [CNT_W-1:0] MAXON_CYC =
      CNT_W'($rtoi($floor(MAX_ON_TIME_US * 1000.0 / CLK_PERIOD_NS)));
   localparam logic [CNT_W-1:0] RESTART_CYC_DEF =
      CNT_W'($rtoi($ceil(RESTART_WAIT_US * 1000.0 / CLK_PERIOD_NS)));
   localparam logic [CNT_W-1:0] STANDBY_CYC_DEF =
      CNT_W'($rtoi($ceil(STANDBY_DELAY_MS * 1000000.0 / CLK_PERIOD_NS)));

   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

   // ==========================================================
   // comparator input vector layout
   localparam int CMP_W = 6;
   localparam int CMP_CS = 0;
   localparam int CMP_BD = 1;
   localparam int CMP_PWM = 2;
   localparam int CMP_BAND = 3;
   localparam int CMP_CODE_LO = 4;
   localparam int CMP_CODE_HI = 5;

   // level select code, also the current reference code
   localparam logic [1:0] REF_DISABLE = 2'h0;
   localparam logic [1:0] REF_750MV = 2'h1;
   localparam logic [1:0] REF_1000MV = 2'h2;
   localparam logic [1:0] REF_1100MV = 2'h3;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      CLB_IDLE = 2'b00,
      CLB_ON = 2'b01,
      CLB_OFF = 2'b10,
      CLB_WAIT = 2'b11
   } clb_state_type;

   typedef struct packed {
      clb_state_type state;
      logic [CNT_W-1:0] timer;
      logic [CNT_W-1:0] stby_cnt;
      logic gate;
      logic standby;
      logic restart;
      logic [1:0] ref_code;
   } clb_ctrl_type;

endpackage

// File: clb_cmp_if.sv
// bundle of filtered comparator levels passed from the input filter to the controller
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface clb_cmp_if;
   logic cs_trip;
   logic bd_low;
   logic pwm_on;
   logic sel_in_band;
   logic [1:0] sel_code;

   modport filt (output cs_trip, output bd_low, output pwm_on, output sel_in_band,
                 output sel_code);
   modport ctrl (input cs_trip, input bd_low, input pwm_on, input sel_in_band,
                 input sel_code);
endinterface

`default_nettype wire

// File: clb_sync.sv
// three-stage input filter for asynchronous comparator levels
// assumes raw inputs may change at any time relative to ref_clk_i
`timescale 1ns/1ps
`default_nettype none

module clb_sync
   import clb_pkg::*;
#(
   parameter int W = CMP_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] raw_i,
   clb_cmp_if.filt cmp
);

   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
      logic [W-1:0] ff3;
      logic [W-1:0] val;
   } clb_sync_type;

   clb_sync_type q;
   clb_sync_type d;

   // ==========================================================
   // stage chain; a bit takes its new value once stages two and three agree
   always_comb begin
      d = q;
      d.ff1 = raw_i;
      d.ff2 = q.ff1;
      d.ff3 = q.ff2;
      for (int i = 0; i < W; i++) begin
         if (q.ff2[i] == q.ff3[i]) begin
            d.val[i] = q.ff3[i];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cmp.cs_trip = q.val[CMP_CS];
   assign cmp.bd_low = q.val[CMP_BD];
   assign cmp.pwm_on = q.val[CMP_PWM];
   assign cmp.sel_in_band = q.val[CMP_BAND];
   assign cmp.sel_code = q.val[CMP_CODE_HI:CMP_CODE_LO];

endmodule // clb_sync

`default_nettype wire

// File: clb_power_model.sv
// behavioural power stage: current-sense and drain bottom comparators
// assumes gate_i comes from the controller on the same 125 MHz clock
`timescale 1ns/1ps
`default_nettype none

module clb_power_model (
   input wire logic ref_clk_i,
   input wire logic gate_i,
   input wire logic [15:0] on_cyc_i,
   input wire logic [15:0] off_cyc_i,
   output logic cs_trip_o,
   output logic bd_low_o
);
   // ==========================================================
   // cycle count since the last gate edge, 0 in a count = never trips
   logic [15:0] cnt;
   logic gate_q;

   // one process drives both comparators, a step after each edge, on the settled gate
   initial begin
      cnt = 16'h0000;
      gate_q = 1'b0;
      cs_trip_o = 1'b0;
      bd_low_o = 1'b0;
      forever begin
         @(posedge ref_clk_i);
         #1;
         if (gate_i !== gate_q) begin
            cnt = 16'h0000;
         end else begin
            cnt = cnt + 16'h0001;
         end
         gate_q = gate_i;
         cs_trip_o = gate_i && (on_cyc_i != 16'h0000) && (cnt >= on_cyc_i);
         // drain rings down only after the inductor has emptied
         bd_low_o = !gate_i && (off_cyc_i != 16'h0000) && (cnt >= off_cyc_i);
      end
   end
endmodule // clb_power_model

`default_nettype wire

// File: crm_led_buck_switch_controller_tb.sv
// self-checking bench of the switching-cycle controller
// assumes clb_switch_ctrl with short restart and standby counts
`timescale 1ns/1ps
`default_nettype none

module crm_led_buck_switch_controller_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_trip;
   logic bd_low;
   logic pwm_on = 1'b0;
   logic sel_in_band = 1'b0;
   logic [1:0] sel_code = 2'h0;
   logic gate;
   logic [1:0] cref;
   logic stby;
   logic rwait;
   logic [15:0] on_cyc = 16'h0032;
   logic [15:0] off_cyc = 16'h00C8;
   int bad_count = 0;
   int n_compared = 0;
   int n;

   always #4 ref_clk = ~ref_clk;

   clb_switch_ctrl #(.RESTART_CYC(24'h000064), .STANDBY_CYC(24'h0000C8)) uut (
      .ref_clk_i(ref_clk), .rst_i(rst), .cs_trip_i(cs_trip), .bd_low_i(bd_low),
      .pwm_on_i(pwm_on), .sel_in_band_i(sel_in_band), .sel_code_i(sel_code),
      .gate_o(gate), .current_ref_o(cref), .standby_o(stby), .restart_wait_o(rwait));

   clb_power_model stage (.ref_clk_i(ref_clk), .gate_i(gate), .on_cyc_i(on_cyc),
      .off_cyc_i(off_cyc), .cs_trip_o(cs_trip), .bd_low_o(bd_low));

   // ==========================================================
   // helpers
   task automatic chk_val(input logic [1:0] got, input logic [1:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task automatic set_in(input logic p, input logic b, input logic [1:0] c);
      @(posedge ref_clk);
      #1;
      pwm_on = p;
      sel_in_band = b;
      sel_code = c;
   endtask

   // cycles during which the gate keeps the given level
   task automatic meas(input logic lvl, input int lim, output int k);
      k = 0;
      while (gate === lvl && k < lim) begin
         cyc(1);
         k++;
      end
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #320000;
      bad_count++;
      $display("watchdog expired");
      end_sim();
   end

   // ==========================================================
   // tests
   initial begin
      cyc(3);
      rst = 1'b0;
      chk_val({1'b0, gate}, 2'h0);
      chk_val(cref, 2'h0);
      chk_val({stby, rwait}, 2'h0);
      $display("test reset done");
      for (int c = 1; c < 4; c++) begin
         set_in(1'b1, 1'b1, 2'(c));
         cyc(6);
         chk_val(cref, 2'(c));
      end
      set_in(1'b1, 1'b0, 2'h1);
      cyc(6);
      chk_val(cref, 2'h3);
      $display("test level select done");
      meas(1'b1, 3000, n);
      meas(1'b0, 3000, n);
      meas(1'b1, 3000, n);
      chk_rng(n, 50, 60);
      meas(1'b0, 3000, n);
      chk_rng(n, 200, 210);
      off_cyc = 16'h000A;
      meas(1'b1, 3000, n);
      meas(1'b0, 3000, n);
      chk_rng(n, 78, 86);
      off_cyc = 16'h0000;
      meas(1'b1, 3000, n);
      meas(1'b0, 3000, n);
      chk_rng(n, 2498, 2504);
      $display("test switching cycle done");
      on_cyc = 16'h0000;
      off_cyc = 16'h00C8;
      meas(1'b1, 3000, n);
      meas(1'b0, 3000, n);
      meas(1'b1, 3000, n);
      chk_rng(n, 2498, 2504);
      chk_val({1'b0, rwait}, 2'h1);
      on_cyc = 16'h0032;
      meas(1'b0, 500, n);
      chk_rng(n, 98, 104);
      chk_val({1'b0, rwait}, 2'h0);
      $display("test max on-time done");
      set_in(1'b1, 1'b1, 2'h0);
      cyc(6);
      chk_val(cref, 2'h0);
      meas(1'b0, 300, n);
      chk_rng(n, 300, 300);
      set_in(1'b1, 1'b1, 2'h2);
      cyc(6);
      chk_val({1'b0, gate}, 2'h1);
      $display("test disable done");
      set_in(1'b0, 1'b1, 2'h2);
      cyc(6);
      chk_val({1'b0, gate}, 2'h0);
      cyc(190);
      chk_val({1'b0, stby}, 2'h0);
      chk_val({1'b0, gate}, 2'h0);
      cyc(20);
      chk_val({1'b0, stby}, 2'h1);
      set_in(1'b1, 1'b1, 2'h2);
      cyc(6);
      chk_val({1'b0, stby}, 2'h0);
      chk_val({1'b0, gate}, 2'h1);
      $display("test dimming done");
      rst = 1'b1;
      cyc(3);
      rst = 1'b0;
      chk_val({gate, rwait}, 2'h0);
      chk_val(cref, 2'h0);
      cyc(6);
      chk_val({gate, stby}, 2'h2);
      chk_val(cref, 2'h2);
      $display("test reset in run done");
      end_sim();
   end
endmodule // crm_led_buck_switch_controller_tb

`default_nettype wire
